// *** rtl/tcpp_pkg.sv ***
/*
 Constants for the true-colour pixel path: register map, field
 positions, reset values, mode codes and pipeline sizes.
 Assumes a 32-bit APB register bus with byte addresses.
*/
package tcpp_pkg;
   // Register byte offsets
   localparam logic [7:0] MUX_OFF = 8'h00; // Multiplex control
   localparam logic [7:0] GEN_OFF = 8'h04; // General control
   localparam logic [7:0] MASK_OFF = 8'h08; // Pixel read mask
   localparam logic [7:0] CLKSEL_OFF = 8'h0c; // Pixels per bus load
   localparam logic [7:0] PADDR_OFF = 8'h10; // Palette index
   localparam logic [7:0] PDATA_OFF = 8'h14; // Palette colour word
   localparam logic [7:0] STAT_OFF = 8'h18; // Status, write 1 to clear
   // Field positions
   localparam int NIBBLE_BIT = 3; // nibble_mode_select_bit
   localparam int SERR_BIT = 2; // serration_select_bit
   localparam int STAT_OVF_BIT = 0; // Buffer overflow, sticky
   localparam int STAT_MODE_LSB = 4; // Active submode, 3 bits
   localparam int STAT_LVL_LSB = 8; // Buffer fill level, 2 bits
   // Reset values
   localparam logic [7:0] MUX_RST = 8'h00;
   localparam logic [7:0] GEN_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] CLKSEL_RST = 8'h01;
   // Submode codes of the six-bit multiplex field
   localparam logic [5:0] CODE_6A = 6'h08;
   localparam logic [5:0] CODE_6B = 6'h09;
   localparam logic [5:0] CODE_6C = 6'h0a;
   localparam logic [5:0] CODE_6D = 6'h0b;
   localparam logic [5:0] CODE_6E = 6'h0e;
   localparam logic [5:0] CODE_6F = 6'h0d;
   // Sizes
   localparam int BUS_W = 32; // Pixel bus width
   localparam int PAL_DEPTH = 256; // Palette entries
   localparam int BUF_DEPTH = 2; // Load buffer entries
   // Active true-colour submode
   typedef enum logic [2:0] {TC_OFF, TC_A, TC_B, TC_C, TC_D, TC_E, TC_F}
      tcpp_mode_e;
   typedef enum logic {SH_IDLE, SH_SHIFT} tcpp_sh_e;
endpackage

// *** rtl/tcpp_top.sv ***
/*
 True-colour pixel path: bus-load latch, two-entry load buffer,
 pixel shifter, overlay palette lookup and DAC output stage, with
 an APB register slave. Assumes load_clk, dot_clk, blank and sync
 pins are asynchronous to ref_clk and much slower than it.
*/
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tcpp_top
   import tcpp_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pixel port pins
   input wire logic [BUS_W-1:0] pixel_bus_bit,
   input wire logic load_clk,
   input wire logic dot_clk,
   input wire logic blank_n,
   input wire logic hsync,
   input wire logic vsync,
   output logic pix_ready,
   // DAC side
   input wire logic dac_ready,
   output logic [7:0] dac_red,
   output logic [7:0] dac_green,
   output logic [7:0] dac_blue,
   output logic dac_blank_n,
   output logic dac_hsync,
   output logic dac_vsync,
   output logic dac_valid
);

   // Submode decode; upper bits never looked at
   function automatic tcpp_mode_e decode_mode(input logic [7:0] mux,
                                              input logic [7:0] gen);
      if (gen[NIBBLE_BIT] && !gen[SERR_BIT])
         decode_mode = TC_OFF;
      else
         case (mux[5:0])
            CODE_6A: decode_mode = TC_A;
            CODE_6B: decode_mode = TC_B;
            CODE_6C: decode_mode = TC_C;
            CODE_6D: decode_mode = TC_D;
            CODE_6E: decode_mode = TC_E;
            CODE_6F: decode_mode = TC_F;
            default: decode_mode = TC_OFF;
         endcase
   endfunction

   // Five-bit channel to eight, low bits zero
   function automatic logic [7:0] wide5(input logic [4:0] c);
      wide5 = {c, 3'b000};
   endfunction

   // Registers
   logic [7:0] mux_reg, mux_next; // Multiplex control
   logic [7:0] gen_reg, gen_next; // General control
   logic [7:0] mask_reg, mask_next; // Pixel read mask
   logic [7:0] clksel_reg, clksel_next; // Held for software only
   logic [7:0] paddr_reg, paddr_next; // Palette index
   logic ovf_reg, ovf_next; // Load arrived with buffer full
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [23:0] pal_mem [PAL_DEPTH]; // Palette, flip-flops
   tcpp_mode_e mode_cur; // Active submode
   logic apb_wr; // Write takes effect
   logic ovf_set;
   logic [1:0] buf_cnt; // Load buffer fill level, read by status
   logic pix_ready_reg; // Room for one more load

   assign mode_cur = decode_mode(mux_reg, gen_reg);
   assign apb_wr = psel && penable && pready_reg && pwrite;

   // Input synchronisers; first stage feeds only the second
   logic [BUS_W-1:0] bus_s1, bus_s2;
   logic [4:0] ctl_s1, ctl_s2; // load, dot, blank_n, hsync, vsync
   logic load_d, dot_d; // Previous synced clock levels
   logic load_rise, dot_rise;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_s1 <= '0;
         bus_s2 <= '0;
         ctl_s1 <= 5'h04;
         ctl_s2 <= 5'h04;
         load_d <= 1'b0;
         dot_d <= 1'b0;
      end
      else
      begin
         bus_s1 <= pixel_bus_bit;
         bus_s2 <= bus_s1;
         ctl_s1 <= {load_clk, dot_clk, blank_n, hsync, vsync};
         ctl_s2 <= ctl_s1;
         load_d <= ctl_s2[4];
         dot_d <= ctl_s2[3];
      end
   end

   // Edges of the slow pixel-side clocks
   assign load_rise = ctl_s2[4] && !load_d;
   assign dot_rise = ctl_s2[3] && !dot_d;

   // Register bus next values
   always_comb
   begin
      mux_next = mux_reg;
      gen_next = gen_reg;
      mask_next = mask_reg;
      clksel_next = clksel_reg;
      paddr_next = paddr_reg;
      ovf_next = ovf_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      pready_next = psel && !penable; // Answer in the access phase
      if (apb_wr)
         case (paddr)
            MUX_OFF: mux_next = pwdata[7:0];
            GEN_OFF: gen_next = pwdata[7:0];
            MASK_OFF: mask_next = pwdata[7:0];
            CLKSEL_OFF: clksel_next = pwdata[7:0];
            PADDR_OFF: paddr_next = pwdata[7:0];
            PDATA_OFF: paddr_next = paddr_reg + 8'h01;
            STAT_OFF: if (pwdata[STAT_OVF_BIT]) ovf_next = 1'b0;
            default: ;
         endcase
      // A new overflow beats a clear in the same cycle
      if (ovf_set)
         ovf_next = 1'b1;
      if (psel && !penable)
      begin
         prdata_next = 32'h0000_0000;
         case (paddr)
            MUX_OFF: prdata_next[7:0] = mux_reg;
            GEN_OFF: prdata_next[7:0] = gen_reg;
            MASK_OFF: prdata_next[7:0] = mask_reg;
            CLKSEL_OFF: prdata_next[7:0] = clksel_reg;
            PADDR_OFF: prdata_next[7:0] = paddr_reg;
            PDATA_OFF: prdata_next[23:0] = pal_mem[paddr_reg];
            STAT_OFF: prdata_next[9:0] = {buf_cnt, 1'b0, mode_cur,
                                          3'b000, ovf_reg};
            default: pslverr_next = 1'b1; // Unmapped address
         endcase
      end
   end

   // Register bus state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mux_reg <= MUX_RST;
         gen_reg <= GEN_RST;
         mask_reg <= MASK_RST;
         clksel_reg <= CLKSEL_RST;
         paddr_reg <= 8'h00;
         ovf_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         mux_reg <= mux_next;
         gen_reg <= gen_next;
         mask_reg <= mask_next;
         clksel_reg <= clksel_next;
         paddr_reg <= paddr_next;
         ovf_reg <= ovf_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Palette storage; no reset so it maps to plain flops
   always_ff @(posedge ref_clk)
   begin
      if (apb_wr && paddr == PDATA_OFF)
         pal_mem[paddr_reg] <= pwdata[23:0];
   end

   // Two-entry load buffer between latch and shifter
   logic [BUS_W-1:0] buf_mem [BUF_DEPTH];
   logic buf_wp, buf_rp; // Write and read index
   logic buf_push, buf_pop, buf_full, buf_empty;

   assign buf_full = buf_cnt == 2'd2;
   assign buf_empty = buf_cnt == 2'd0;
   // A load with no room is dropped and flagged
   assign buf_push = load_rise && mode_cur != TC_OFF && !buf_full;
   assign ovf_set = load_rise && mode_cur != TC_OFF && buf_full;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_cnt <= 2'd0;
      end
      else
      begin
         buf_wp <= buf_wp ^ buf_push;
         buf_rp <= buf_rp ^ buf_pop;
         buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // Whole bus word is latched at once
   always_ff @(posedge ref_clk)
   begin
      if (buf_push)
         buf_mem[buf_wp] <= bus_s2;
   end

   // Shifter and two output stages
   tcpp_sh_e sh_reg, sh_next;
   logic [BUS_W-1:0] word_reg, word_next; // Current bus load
   logic grp_reg, grp_next; // Group being shifted
   logic adv; // One pixel time, receiver willing
   logic two_pix; // Two pixels per load
   logic emit; // A group leaves the shifter
   logic last_grp;
   logic [15:0] half; // Selected 16-bit group
   logic [23:0] s1_dir_reg, s1_dir_next; // Direct colour R,G,B
   logic [7:0] s1_ovl_reg, s1_ovl_next; // Masked overlay index
   logic [2:0] s1_ctl_reg, s1_ctl_next; // blank_n, hsync, vsync
   logic [23:0] rgb_next;
   logic [23:0] rgb_reg;
   logic [2:0] ctl_reg;
   logic valid_reg;

   assign adv = dot_rise && dac_ready;
   assign two_pix = mode_cur == TC_C || mode_cur == TC_D;
   assign emit = sh_reg == SH_SHIFT && adv;
   assign last_grp = !two_pix || grp_reg;
   assign half = grp_reg ? word_reg[31:16] : word_reg[15:0];
   assign buf_pop = !buf_empty && (sh_reg == SH_IDLE ||
                                   (emit && last_grp));

   // Shifter next state and first pipeline stage
   always_comb
   begin
      sh_next = sh_reg;
      word_next = word_reg;
      grp_next = grp_reg;
      s1_dir_next = s1_dir_reg;
      s1_ovl_next = s1_ovl_reg;
      s1_ctl_next = s1_ctl_reg;
      case (sh_reg)
         SH_IDLE:
            if (buf_pop)
               sh_next = SH_SHIFT;
         SH_SHIFT:
            if (emit)
            begin
               grp_next = !last_grp;
               if (last_grp && !buf_pop)
                  sh_next = SH_IDLE;
            end
         default: sh_next = SH_IDLE;
      endcase
      if (buf_pop)
      begin
         word_next = buf_mem[buf_rp];
         grp_next = 1'b0;
      end
      if (adv)
      begin
         // Blanking and sync move with the colour
         s1_ctl_next = ctl_s2[2:0];
         s1_dir_next = 24'h00_0000;
         s1_ovl_next = 8'h00;
         if (emit)
            case (mode_cur)
               TC_A, TC_C:
               begin
                  s1_dir_next = {wide5(half[14:10]), wide5(half[9:5]),
                                 wide5(half[4:0])};
                  s1_ovl_next = {7'b000_0000, half[15]} & mask_reg;
               end
               TC_B, TC_D:
                  s1_dir_next = {wide5(half[15:11]), half[10:5], 2'b00,
                                 wide5(half[4:0])};
               TC_E, TC_F:
               begin
                  s1_dir_next = {word_reg[15:8], word_reg[23:16],
                                 word_reg[31:24]};
                  s1_ovl_next = word_reg[7:0] & mask_reg;
               end
               default: ;
            endcase
      end
   end

   // Overlay takes priority when its index is nonzero
   always_comb
   begin
      if (s1_ovl_reg != 8'h00)
         rgb_next = pal_mem[s1_ovl_reg];
      else
         rgb_next = s1_dir_reg;
   end

   // Pipeline registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_reg <= SH_IDLE;
         word_reg <= '0;
         grp_reg <= 1'b0;
         s1_dir_reg <= 24'h00_0000;
         s1_ovl_reg <= 8'h00;
         s1_ctl_reg <= 3'h4;
         rgb_reg <= 24'h00_0000;
         ctl_reg <= 3'h4;
         valid_reg <= 1'b0;
      end
      else
      begin
         sh_reg <= sh_next;
         word_reg <= word_next;
         grp_reg <= grp_next;
         s1_dir_reg <= s1_dir_next;
         s1_ovl_reg <= s1_ovl_next;
         s1_ctl_reg <= s1_ctl_next;
         valid_reg <= adv;
         if (adv)
         begin
            rgb_reg <= rgb_next;
            ctl_reg <= s1_ctl_reg;
         end
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pix_ready = pix_ready_reg;
   assign {dac_red, dac_green, dac_blue} = rgb_reg;
   assign {dac_blank_n, dac_hsync, dac_vsync} = ctl_reg;
   assign dac_valid = valid_reg;

   // Registered ready for the pin; an empty buffer has room
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pix_ready_reg <= 1'b1;
      else
         pix_ready_reg <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop}
                          != 2'd2;
   end

   // Checks; one clock domain, quiet during reset
   default clocking chk_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_emit_lo;
      emit && two_pix && !grp_reg;
   endsequence
   sequence seq_emit_hi;
      emit && two_pix && grp_reg;
   endsequence

   AST_DIRECT_PASS: assert property (
      adv && s1_ovl_reg == 8'h00 |=> rgb_reg == $past(s1_dir_reg))
      else $error("direct colour not passed with zero overlay");
   AST_OVERLAY_WINS: assert property (
      adv && s1_ovl_reg != 8'h00 |=> rgb_reg == pal_mem[$past(s1_ovl_reg)])
      else $error("overlay colour not shown");
   AST_SAME_DELAY: assert property (
      adv && s1_ovl_reg == 8'h00 |=>
      {rgb_reg, ctl_reg} == $past({s1_dir_reg, s1_ctl_reg}))
      else $error("colour and controls left stage one apart");
   AST_CTL_DELAY: assert property (
      adv |=> ctl_reg == $past(s1_ctl_reg) &&
      s1_ctl_reg == $past(ctl_s2[2:0]))
      else $error("blank or sync off the colour pipeline");
   AST_HI_BITS_IGNORED: assert property (
      $stable(mux_reg[5:0]) && $stable(gen_reg) |-> $stable(mode_cur))
      else $error("mode follows bits 6 or 7");
   AST_NIBBLE_OVERRIDE: assert property (
      gen_reg[NIBBLE_BIT] && !gen_reg[SERR_BIT] |-> mode_cur == TC_OFF)
      else $error("true colour active in nibble mode");
   AST_LOW_HALF_FIRST: assert property (
      seq_emit_lo |=> grp_reg && $past(mode_cur) == TC_D |->
      s1_dir_reg[7:3] == $past(word_reg[4:0]))
      else $error("first pixel not from low half");
   AST_HIGH_HALF_NEXT: assert property (
      seq_emit_hi |=> !grp_reg && $past(mode_cur) == TC_D |->
      s1_dir_reg[7:3] == $past(word_reg[20:16]))
      else $error("second pixel not from high half");
   AST_TRUE24_MAP: assert property (
      emit && mode_cur == TC_E |=> s1_dir_reg == {$past(word_reg[15:8]),
      $past(word_reg[23:16]), $past(word_reg[31:24])})
      else $error("24-bit lanes misrouted");
   AST_MASK_FIRST: assert property (
      adv |=> (s1_ovl_reg & ~$past(mask_reg)) == 8'h00)
      else $error("overlay index escaped the read mask");
endmodule

// *** verif/tcpp_gfx_model.sv ***
/*
 Graphics controller model: drives the pixel bus, the bus-load and
 pixel clocks, blanking and sync. Assumes an 80 ns link clock that
 stands still between loads and frames.
*/
`timescale 1ns/1ps
module tcpp_gfx_model
(
   // Pixel port pins
   output logic [31:0] pixel_bus_bit,
   output logic load_clk,
   output logic dot_clk,
   output logic blank_n,
   output logic hsync,
   output logic vsync
);
   // Quiet pins at time zero
   initial
   begin
      pixel_bus_bit = 32'h0000_0000;
      load_clk = 1'b0;
      dot_clk = 1'b0;
      {blank_n, hsync, vsync} = 3'h4;
   end
   // One bus load; after the hold the bus shows the inverse, not stale
   task load(input logic [31:0] w, input logic [2:0] ctl);
      pixel_bus_bit <= w;
      {blank_n, hsync, vsync} <= ctl;
      #20 load_clk <= 1'b1;
      #40 load_clk <= 1'b0;
      // Inverse well before the next load drives the bus again
      #20 pixel_bus_bit <= ~w;
      #20;
   endtask
   // Pixel times, one per 80 ns period
   task dots(input int n);
      repeat (n)
      begin
         #40 dot_clk <= 1'b1;
         #40 dot_clk <= 1'b0;
      end
   endtask
endmodule

// *** verif/testbench.sv ***
/*
 Self-checking bench for the true-colour pixel path: APB register
 access, every submode, overlay masking, nibble override and buffer
 stall. Assumes the graphics controller model drives the pixel pins.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench
   import tcpp_pkg::*;
;
   // Clock, reset and APB master
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Pixel pins from the model
   wire [31:0] pix;
   wire load_clk, dot_clk, blank_n, hsync, vsync;
   // DAC side
   logic pix_ready;
   logic dac_ready = 1'b1;
   logic [7:0] dac_red, dac_green, dac_blue;
   logic dac_blank_n, dac_hsync, dac_vsync, dac_valid;
   // Bench state
   int n_mismatch = 0;
   int n_compared = 0;
   logic [15:0] lfsr_q = 16'h9ba9; // Seed 39849
   logic [23:0] pal [256]; // Mirror of palette
   logic [26:0] got [$]; // Seen {rgb, blank, hsync, vsync}
   logic [26:0] exp_q [$];
   logic [31:0] rd;
   logic err;
   logic [5:0] codes [6] = '{CODE_6A, CODE_6B, CODE_6C, CODE_6D,
                             CODE_6E, CODE_6F};
   int ppl [6] = '{1, 1, 2, 2, 1, 1}; // Pixels per load
   logic [7:0] offs [4] = '{MUX_OFF, GEN_OFF, MASK_OFF, CLKSEL_OFF};
   logic [7:0] rsts [4] = '{MUX_RST, GEN_RST, MASK_RST, CLKSEL_RST};

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   tcpp_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pixel_bus_bit(pix), .load_clk(load_clk),
      .dot_clk(dot_clk), .blank_n(blank_n), .hsync(hsync),
      .vsync(vsync), .pix_ready(pix_ready), .dac_ready(dac_ready),
      .dac_red(dac_red), .dac_green(dac_green), .dac_blue(dac_blue),
      .dac_blank_n(dac_blank_n), .dac_hsync(dac_hsync),
      .dac_vsync(dac_vsync), .dac_valid(dac_valid));

   tcpp_gfx_model gfx (.pixel_bus_bit(pix), .load_clk(load_clk),
      .dot_clk(dot_clk), .blank_n(blank_n), .hsync(hsync),
      .vsync(vsync));

   // Collect every pixel update
   always @(posedge ref_clk)
      if (dac_valid === 1'b1)
         got.push_back({dac_red, dac_green, dac_blue, dac_blank_n,
                        dac_hsync, dac_vsync});

   // Verdict and end of run
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [31:0] rnd32();
      logic [31:0] r;
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^
                lfsr_q[10]};
      r[15:0] = lfsr_q;
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^
                lfsr_q[10]};
      r[31:16] = lfsr_q;
      return r;
   endfunction

   // Expected DAC colour of one pixel group
   function automatic logic [23:0] exp_rgb(input int m,
      input logic [31:0] w, input int h, input logic [7:0] mk);
      logic [15:0] g;
      logic [7:0] idx;
      logic [23:0] d;
      g = (h == 1) ? w[31:16] : w[15:0];
      idx = 8'h00;
      if (m == 0 || m == 2)
      begin
         d = {g[14:10], 3'h0, g[9:5], 3'h0, g[4:0], 3'h0};
         idx = {7'h00, g[15]};
      end
      else if (m < 4)
         d = {g[15:11], 3'h0, g[10:5], 2'h0, g[4:0], 3'h0};
      else
      begin
         d = {w[15:8], w[23:16], w[31:24]};
         idx = w[7:0];
      end
      idx = idx & mk;
      return (idx != 8'h00) ? pal[idx] : d;
   endfunction

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         `CHK("pready", 1'b1, pready);
         conclude();
      end
   endtask

   // Pixel updates seen against those expected, aligned at the tail
   task automatic cmp_q();
      int off;
      off = got.size() - exp_q.size();
      `CHK("pixel count", 1'b1, off >= 0);
      foreach (exp_q[i])
         if (off >= 0) `CHK("pixel", exp_q[i], got[off + i]);
   endtask

   // Four random loads, corner words among them, then a flush
   task automatic frame(input int m, input logic [7:0] mk);
      logic [31:0] w;
      logic [31:0] r;
      got.delete();
      exp_q.delete();
      for (int i = 0; i < 4; i++)
      begin
         w = rnd32();
         r = rnd32();
         if (i == 1) w = w & 32'hffff_7f00;
         if (i == 2) w[7:0] = 8'hf0;
         for (int h = 0; h < ppl[m]; h++)
            exp_q.push_back({exp_rgb(m, w, h, mk), r[2:0]});
         gfx.load(w, r[2:0]);
         gfx.dots(ppl[m]);
      end
      gfx.dots(1);
      repeat (10) @(posedge ref_clk);
      cmp_q();
   endtask

   // Main sequence
   initial
   begin
      logic [7:0] mk;
      int i;
      repeat (20) @(posedge ref_clk);
      `CHK("reset blank", 1'b1, dac_blank_n);
      rst_n <= 1'b1;
      foreach (offs[k])
      begin
         apb(1'b0, offs[k], 32'h0000_0000);
         `CHK("reset value", {24'h00_0000, rsts[k]}, rd);
      end
      apb(1'b0, 8'h1c, 32'h0000_0000);
      `CHK("unmapped", 1'b1, err);
      apb(1'b1, PADDR_OFF, 32'h0000_0000);
      foreach (pal[k])
      begin
         pal[k] = 24'(rnd32());
         apb(1'b1, PDATA_OFF, {8'h00, pal[k]});
      end
      apb(1'b1, PADDR_OFF, 32'h0000_0005);
      apb(1'b0, PDATA_OFF, 32'h0000_0000);
      `CHK("palette", pal[5], rd[23:0]);
      $display("test registers done");
      for (int m = 0; m < 6; m++)
      begin
         mk = (m == 0) ? 8'hfe : 8'h0f;
         apb(1'b1, MASK_OFF, {24'h00_0000, mk});
         apb(1'b1, MUX_OFF, {24'h00_0000, m[0], m[0], codes[m]});
         apb(1'b0, STAT_OFF, 32'h0000_0000);
         `CHK("mode", 3'(m + 1), rd[6:4]);
         apb(1'b1, CLKSEL_OFF, 32'(ppl[m]));
         frame(m, mk);
         $display("test submode %0d done", m);
      end
      // Nibble mode overrides the submode
      apb(1'b1, GEN_OFF, 32'h0000_0008);
      apb(1'b0, STAT_OFF, 32'h0000_0000);
      `CHK("nibble mode", 3'h0, rd[6:4]);
      got.delete();
      gfx.load(rnd32(), 3'h4);
      gfx.dots(2);
      repeat (10) @(posedge ref_clk);
      `CHK("nibble out", 2, got.size());
      `CHK("nibble blank", 27'h000_0004, got[1]);
      apb(1'b1, GEN_OFF, 32'h0000_0000);
      $display("test nibble done");
      // Stall the receiver and fill the buffer until refused
      apb(1'b1, MUX_OFF, {26'h000_0000, CODE_6E});
      apb(1'b1, MASK_OFF, 32'h0000_00ff);
      apb(1'b1, CLKSEL_OFF, 32'h0000_0001);
      got.delete();
      exp_q.delete();
      dac_ready <= 1'b0;
      for (i = 0; i < 5 && pix_ready !== 1'b0; i++)
      begin
         rd = rnd32();
         exp_q.push_back({exp_rgb(4, rd, 0, 8'hff), 3'h4});
         gfx.load(rd, 3'h4);
      end
      `CHK("buffer full", 1'b0, pix_ready);
      apb(1'b0, STAT_OFF, 32'h0000_0000);
      `CHK("level", 2'h2, rd[9:8]);
      gfx.load(rnd32(), 3'h4);
      gfx.dots(2);
      apb(1'b0, STAT_OFF, 32'h0000_0000);
      `CHK("overflow", 1'b1, rd[0]);
      `CHK("stalled out", 0, got.size());
      apb(1'b1, STAT_OFF, 32'h0000_0001);
      apb(1'b0, STAT_OFF, 32'h0000_0000);
      `CHK("overflow clear", 1'b0, rd[0]);
      @(posedge ref_clk);
      dac_ready <= 1'b1;
      gfx.dots(i + 1);
      repeat (10) @(posedge ref_clk);
      cmp_q();
      $display("test buffer done");
      conclude();
   end
endmodule
